// >>> src/mac_status_regs.sv
// MAC status flags, test-mode controls and PHY management registers on APB.
// Assumes events are one-cycle pulses from MAC logic on core_clk and that
// the PHY mdio pin is asynchronous to core_clk.
//
// Added by the designer: the APB interface to the registers.

// How it works
// - Excess-collision flag sets when one frame's collisions reach 16 without a late collision.
// - Late-collision flag sets on a late transmit collision; write one clears.
// - Transmit-lost flag sets when a frame is abandoned by late or excess collisions.
// - Transmit-done flag sets on each error-free transmitted frame.
// - Runt flag sets when a received frame is below minimum length.
// - Oversize flag sets when a received frame exceeds the long-frame limit.
// - CRC flag sets on a bad frame check unless checking is off.
// - Receive-dropped flag sets when a frame is lost to a full FIFO.
// - Receive-stored flag sets when a frame is stored without FIFO overflow, collision or checked CRC error.
// - Status bit 2 flags frames dropped because of a collision.
// - Bit 1 flags broadcast, bit 0 flags multicast destinations received.
// - Test bit 20 puts the polling timer in test mode; resets to zero.
// - Test bit 19 puts the interrupt timer in test mode; resets to zero.
// - Collision test bit 15 selects programmed back-off from bits 14 to 5.
// - In collision test mode retries are limited by bits 4 to 0.
// - Bit 27 starts a PHY write of data low half to addressed register.
// - Bit 26 starts a PHY read; result lands in data upper half.
// - Write-start bit clears itself when the write frame completes.
// - Read-start bit clears itself when read data is available.
// - Management clock period equals divider times system clock period; resets 0x52.
// - Without jumbo mode frames over 1518, or 1522 tagged, are too long.
// - Frames under 64 bytes are runts unless runt reception is enabled.
module mac_status_regs (
  input  wire logic                     core_clk,          // System clock, 100 MHz.
  input  wire logic                     sys_rst,           // Synchronous reset, active high.
  input  wire logic                     psel,              // APB select.
  input  wire logic                     penable,           // APB access phase.
  input  wire logic                     pwrite,            // APB write.
  input  wire logic [7:0]               paddr,             // APB byte address.
  input  wire logic [31:0]              pwdata,            // APB write data.
  output logic      [31:0]              prdata,            // APB read data.
  output logic                          pready,            // APB ready.
  output logic                          pslverr,           // APB error, unmapped address.
  input  wire mac_stat_pkg::mac_event_s evt,               // MAC event pulses.
  input  wire logic                     fcs_check_off,     // CRC checking disabled.
  input  wire logic                     jumbo_length_select, // Jumbo long-frame mode.
  input  wire logic                     rx_runt_accept,    // Runt reception enabled.
  output logic                          poll_timer_test,   // Polling timer test mode.
  output logic                          irq_timer_test,    // Interrupt timer test mode.
  output logic                          test_collision,    // Collision test mode.
  output logic      [9:0]               test_backoff_value, // Forced back-off value.
  output logic      [4:0]               test_retry_limit,  // Retry limit, valid in test mode.
  output logic                          mdc,               // Management clock out.
  input  wire logic                     mdio_in,           // Management data pin level.
  output logic                          mdio_out,          // Management data drive value.
  output logic                          mdio_oe            // High while driving mdio.
);
  import mac_stat_pkg::*;

  logic [NUM_EVT-1:0] flags_ff;
  logic [NUM_EVT-1:0] evt_hit;
  logic [31:0]        test_ff;
  logic               wr_go_ff;
  logic               rd_go_ff;
  logic [4:0]         phy_reg_index;
  logic [4:0]         phy_port_id;
  logic [7:0]         mgmt_clk_divider;
  logic [15:0]        mgmt_write_value;
  logic [15:0]        mgmt_read_value;
  logic               busy_ff;
  logic               mdio_meta_ff;
  logic               mdio_sync_ff;
  logic               eng_done;
  logic [15:0]        eng_rdata;
  logic               eng_mdc;
  logic               eng_out;
  logic               eng_oe;
  logic               wr_en;
  logic               rd_en;
  logic               w1c_hit;
  logic [31:0]        nxt_prdata;
  logic               nxt_pslverr;
  logic [13:0]        long_limit;
  mgmt_req_s          req;

  assign wr_en   = psel && penable && pwrite && pready;
  assign rd_en   = psel && !penable && !pwrite;
  assign w1c_hit = wr_en && (paddr == MAC_EVENT_STATUS_OFS);

  always_comb begin
    if (jumbo_length_select) begin
      long_limit = evt.rx_vlan ? 14'(JUMBO_FRAME_VLN) : 14'(JUMBO_FRAME);
    end else begin
      long_limit = evt.rx_vlan ? 14'(MAX_FRAME_VLAN) : 14'(MAX_FRAME);
    end
  end

  // Event vector in status-bit order, bit 0 upward.
  always_comb begin
    evt_hit             = '0;
    evt_hit[ST_MULTI]   = evt.rx_end && evt.rx_mcast;
    evt_hit[ST_BCAST]   = evt.rx_end && evt.rx_bcast;
    evt_hit[ST_COLDRP]  = evt.rx_end && evt.rx_col;
    evt_hit[3]          = evt.rx_end && !evt.rx_fifo_full && !evt.rx_col
                          && !(evt.rx_crc_bad && !fcs_check_off);
    evt_hit[4]          = evt.rx_end && evt.rx_fifo_full;
    evt_hit[5]          = evt.rx_end && evt.rx_crc_bad && !fcs_check_off;
    evt_hit[6]          = evt.rx_end && (evt.rx_len > long_limit);
    evt_hit[7]          = evt.rx_end && !rx_runt_accept
                          && (evt.rx_len < 14'(MIN_FRAME));
    evt_hit[8]          = evt.tx_end && evt.tx_ok;
    evt_hit[9]          = evt.tx_end && !evt.tx_ok
                          && (evt.tx_late_col || evt.tx_col_count > 5'(COLL_LIMIT - 1));
    evt_hit[10]         = evt.tx_late_col;
  end

  // Excess collision: 16 or more attempts means count reached its saturating 16+.
  logic excess_collision_flag;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      excess_collision_flag <= 1'b0;
    end else if (evt.tx_end && evt.tx_col_count > 5'(COLL_LIMIT - 1) && !evt.tx_late_col) begin
      excess_collision_flag <= 1'b1;
    end else if (w1c_hit && pwdata[11]) begin
      excess_collision_flag <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi++) begin : g_flag
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          flags_ff[gi] <= 1'b0;
        end else if (evt_hit[gi]) begin
          flags_ff[gi] <= 1'b1;
        end else if (w1c_hit && pwdata[gi]) begin
          flags_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      test_ff <= 32'h0000_0000;
    end else if (wr_en && paddr == TEST_CONTROL_OFS) begin
      test_ff <= pwdata & 32'h0018_FFFF;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      poll_timer_test    <= 1'b0;
      irq_timer_test     <= 1'b0;
      test_collision     <= 1'b0;
      test_backoff_value <= 10'h000;
      test_retry_limit   <= 5'h00;
    end else begin
      poll_timer_test    <= test_ff[TC_POLL];
      irq_timer_test     <= test_ff[TC_IRQ];
      test_collision     <= test_ff[TC_COL];
      test_backoff_value <= test_ff[TC_BKO_HI:TC_BKO_LO];
      test_retry_limit   <= test_ff[TC_RTY_HI:0];
    end
  end

  // Control fields; start bits ignore new writes while a frame is running.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_go_ff         <= 1'b0;
      rd_go_ff         <= 1'b0;
      phy_reg_index    <= 5'h00;
      phy_port_id      <= 5'h00;
      mgmt_clk_divider <= MGMT_CLK_DIV_RST;
    end else begin
      if (eng_done) begin
        wr_go_ff <= 1'b0;
        rd_go_ff <= 1'b0;
      end else if (wr_en && paddr == PHY_MGMT_CONTROL_OFS && !busy_ff) begin
        wr_go_ff         <= pwdata[PC_WR];
        rd_go_ff         <= pwdata[PC_RD] && !pwdata[PC_WR];
        phy_reg_index    <= pwdata[PC_REG_HI:PC_REG_LO];
        phy_port_id      <= pwdata[PC_PHY_HI:PC_PHY_LO];
        mgmt_clk_divider <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_ff <= 1'b0;
    end else if (eng_done) begin
      busy_ff <= 1'b0;
    end else if (req.go) begin
      busy_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mgmt_write_value <= 16'h0000;
    end else if (wr_en && paddr == PHY_MGMT_DATA_OFS) begin
      mgmt_write_value <= pwdata[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mgmt_read_value <= 16'h0000;
    end else if (eng_done && rd_go_ff) begin
      mgmt_read_value <= eng_rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mdio_meta_ff <= 1'b1;
      mdio_sync_ff <= 1'b1;
    end else begin
      mdio_meta_ff <= mdio_in;
      mdio_sync_ff <= mdio_meta_ff;
    end
  end

  // The divider is loaded by the same write as the start bit; a divider below 2 stalls mdc.
  always_comb begin
    req.go            = (wr_go_ff || rd_go_ff) && !busy_ff;
    req.is_read       = rd_go_ff;
    req.phy_port_id   = phy_port_id;
    req.phy_reg_index = phy_reg_index;
    req.wdata         = mgmt_write_value;
    req.div           = mgmt_clk_divider;
  end

  mdio_engine u_mdio (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .req          (req),
    .mdio_in_sync (mdio_sync_ff),
    .done         (eng_done),
    .rdata        (eng_rdata),
    .mdc          (eng_mdc),
    .mdio_out     (eng_out),
    .mdio_oe      (eng_oe)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mdc      <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe  <= 1'b0;
    end else begin
      mdc      <= eng_mdc;
      mdio_out <= eng_out;
      mdio_oe  <= eng_oe;
    end
  end

  always_comb begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    case (paddr)
      MAC_EVENT_STATUS_OFS: nxt_prdata = {20'h0, excess_collision_flag, flags_ff};
      TEST_CONTROL_OFS:     nxt_prdata = test_ff;
      PHY_MGMT_CONTROL_OFS: nxt_prdata = {4'h0, wr_go_ff, rd_go_ff, phy_reg_index,
                                          phy_port_id, 8'h00, mgmt_clk_divider};
      PHY_MGMT_DATA_OFS:    nxt_prdata = {mgmt_read_value, mgmt_write_value};
      default:              nxt_pslverr = 1'b1;
    endcase
  end

  // Answer one cycle after setup: zero wait states on every access.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && nxt_pslverr;
      if (rd_en) begin
        prdata <= nxt_prdata;
      end
    end
  end

endmodule : mac_status_regs

// >>> src/mac_stat_pkg.sv
// Package for the MAC status, test-mode and PHY management register block.
// Assumes a 100 MHz core clock and an APB register bus with 32-bit data.
package mac_stat_pkg;

  localparam logic [7:0]  MAC_EVENT_STATUS_OFS = 8'h54;
  localparam logic [7:0]  TEST_CONTROL_OFS     = 8'h58;
  localparam logic [7:0]  PHY_MGMT_CONTROL_OFS = 8'h60;
  localparam logic [7:0]  PHY_MGMT_DATA_OFS    = 8'h64;
  localparam logic [7:0]  PHY_RX_CFG_OFS       = 8'h70;

  localparam logic [31:0] PHY_MGMT_CONTROL_RST = 32'h0000_0052;
  localparam logic [7:0]  MGMT_CLK_DIV_RST     = 8'h52;

  // Status bit positions; bits 3..10 map onto the event vector in order.
  localparam int unsigned ST_MULTI  = 0;
  localparam int unsigned ST_BCAST  = 1;
  localparam int unsigned ST_COLDRP = 2;
  localparam int unsigned ST_EVT_LO = 3;
  localparam int unsigned NUM_EVT   = 11;

  localparam int unsigned TC_POLL   = 20;
  localparam int unsigned TC_IRQ    = 19;
  localparam int unsigned TC_COL    = 15;
  localparam int unsigned TC_BKO_HI = 14;
  localparam int unsigned TC_BKO_LO = 5;
  localparam int unsigned TC_RTY_HI = 4;

  localparam int unsigned PC_WR     = 27;
  localparam int unsigned PC_RD     = 26;
  localparam int unsigned PC_REG_HI = 25;
  localparam int unsigned PC_REG_LO = 21;
  localparam int unsigned PC_PHY_HI = 20;
  localparam int unsigned PC_PHY_LO = 16;

  localparam int unsigned COLL_LIMIT      = 16;
  localparam int unsigned MIN_FRAME       = 64;
  localparam int unsigned MAX_FRAME       = 1518;
  localparam int unsigned MAX_FRAME_VLAN  = 1522;
  localparam int unsigned JUMBO_FRAME     = 9216;
  localparam int unsigned JUMBO_FRAME_VLN = 9220;
  localparam int unsigned PREAMBLE_BITS   = 32;
  localparam int unsigned MDIO_FRAME_BITS = 64;

  typedef enum logic [1:0] {
    MG_IDLE = 2'b00,
    MG_SHIFT = 2'b01,
    MG_DONE = 2'b10
  } mgmt_state_e;

  typedef struct packed {
    logic        tx_end;
    logic        tx_ok;
    logic        tx_late_col;
    logic [4:0]  tx_col_count;
    logic        rx_end;
    logic [13:0] rx_len;
    logic        rx_vlan;
    logic        rx_crc_bad;
    logic        rx_fifo_full;
    logic        rx_col;
    logic        rx_bcast;
    logic        rx_mcast;
  } mac_event_s;

  typedef struct packed {
    logic       go;
    logic       is_read;
    logic [4:0] phy_port_id;
    logic [4:0] phy_reg_index;
    logic [15:0] wdata;
    logic [7:0] div;
  } mgmt_req_s;

endpackage : mac_stat_pkg

// >>> src/mdio_engine.sv
// Clause 22 serial management engine: builds the frame and shifts it on mdc.
// Assumes mdio_in arrives already synchronised to core_clk.
module mdio_engine (
  input  wire logic                   core_clk,      // System clock.
  input  wire logic                   sys_rst,       // Synchronous reset, active high.
  input  wire mac_stat_pkg::mgmt_req_s req,          // Transaction request.
  input  wire logic                   mdio_in_sync,  // Synchronised mdio level.
  output logic                        done,          // One-cycle completion pulse.
  output logic [15:0]                 rdata,         // Data read from the PHY.
  output logic                        mdc,           // Management clock.
  output logic                        mdio_out,      // Driven mdio level.
  output logic                        mdio_oe        // High while driving mdio.
);
  import mac_stat_pkg::*;

  mgmt_state_e state_ff;
  logic [7:0]  div_cnt_ff;
  logic [6:0]  bit_cnt_ff;
  logic [63:0] shift_ff;
  logic        rd_ff;
  logic        rise;
  logic        fall;
  logic [7:0]  half;

  // Period is div cycles: low for the first half, high for the rest.
  assign half = req.div >> 1;
  assign fall = (state_ff == MG_SHIFT) && (div_cnt_ff == 8'h00);
  assign rise = (state_ff == MG_SHIFT) && (div_cnt_ff == half);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_cnt_ff <= 8'h00;
    end else if (state_ff != MG_SHIFT || div_cnt_ff + 8'h01 >= req.div) begin
      div_cnt_ff <= 8'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff   <= MG_IDLE;
      bit_cnt_ff <= 7'h00;
      shift_ff   <= 64'h0;
      rd_ff      <= 1'b0;
      rdata      <= 16'h0000;
      done       <= 1'b0;
      mdc        <= 1'b0;
      mdio_out   <= 1'b1;
      mdio_oe    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_ff)
        MG_IDLE: begin
          mdc     <= 1'b0;
          mdio_oe <= 1'b0;
          if (req.go) begin
            // Preamble, start 01, opcode, addresses, turnaround, data.
            shift_ff <= {32'hFFFF_FFFF, 2'b01, req.is_read ? 2'b10 : 2'b01,
                         req.phy_port_id, req.phy_reg_index, 2'b10, req.wdata};
            rd_ff      <= req.is_read;
            bit_cnt_ff <= 7'h00;
            state_ff   <= MG_SHIFT;
          end
        end
        MG_SHIFT: begin
          if (fall) begin
            mdc      <= 1'b0;
            mdio_out <= shift_ff[63];
            // A read releases the line from the turnaround onward.
            mdio_oe  <= !(rd_ff && bit_cnt_ff >= 7'd46);
            shift_ff <= {shift_ff[62:0], 1'b0};
          end
          if (rise) begin
            mdc        <= 1'b1;
            bit_cnt_ff <= bit_cnt_ff + 7'h01;
            if (bit_cnt_ff >= 7'd48) begin
              rdata <= {rdata[14:0], mdio_in_sync};
            end
            if (bit_cnt_ff == 7'(MDIO_FRAME_BITS - 1)) begin
              state_ff <= MG_DONE;
            end
          end
        end
        MG_DONE: begin
          mdc      <= 1'b0;
          mdio_oe  <= 1'b0;
          done     <= 1'b1;
          state_ff <= MG_IDLE;
        end
        default: state_ff <= MG_IDLE;
      endcase
    end
  end

endmodule : mdio_engine

// >>> verif/mac_status_sva.sv
// Checker for the MAC status and PHY management block, bound to its ports.
// Assumes a single core_clk domain and one APB master.
module mac_status_sva
  import mac_stat_pkg::*;
(
  input wire logic        core_clk,           // System clock.
  input wire logic        sys_rst,            // Synchronous reset.
  input wire logic        psel,               // APB select.
  input wire logic        penable,            // APB access phase.
  input wire logic        pwrite,             // APB write.
  input wire logic [7:0]  paddr,              // APB address.
  input wire logic [31:0] pwdata,             // APB write data.
  input wire logic        pready,             // APB ready.
  input wire logic        pslverr,            // APB error.
  input wire logic        poll_timer_test,    // Poll timer test.
  input wire logic        irq_timer_test,     // Irq timer test.
  input wire logic        test_collision,     // Collision test.
  input wire logic [9:0]  test_backoff_value, // Forced back-off.
  input wire logic [4:0]  test_retry_limit,   // Retry limit.
  input wire logic        mdc,                // Management clock.
  input wire logic        mdio_out,           // Management data out.
  input wire logic        mdio_oe             // Management drive enable.
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic wr_tc;
  logic mapped;
  assign wr_tc = psel && penable && pready && pwrite && (paddr == TEST_CONTROL_OFS);
  assign mapped = paddr inside {MAC_EVENT_STATUS_OFS, TEST_CONTROL_OFS,
                                PHY_MGMT_CONTROL_OFS, PHY_MGMT_DATA_OFS};
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("long pready");
  chk_err_unmapped: assert property (pslverr |-> pready && !mapped)
    else $error("bad pslverr");
  chk_poll_follow: assert property (wr_tc |-> ##2 poll_timer_test == $past(pwdata[20], 2))
    else $error("poll bit");
  chk_irq_follow: assert property (wr_tc |-> ##2 irq_timer_test == $past(pwdata[19], 2))
    else $error("irq bit");
  chk_backoff_follow: assert property (wr_tc |-> ##2 {test_collision, test_backoff_value}
                                       == $past(pwdata[15:5], 2))
    else $error("collision fields");
  chk_retry_follow: assert property (wr_tc |-> ##2 test_retry_limit == $past(pwdata[4:0], 2))
    else $error("retry limit");
  chk_reset_idle: assert property ($fell(sys_rst) |-> mdio_out && !mdio_oe && !mdc)
    else $error("pins not idle");
  chk_frame_start: assert property ($rose(mdio_oe) |-> mdio_out)
    else $error("no preamble one");
  cov_test_write: cover property (wr_tc);
  cov_unmapped: cover property (pslverr);
  cov_frame: cover property ($rose(mdio_oe));
endmodule : mac_status_sva

bind mac_status_regs mac_status_sva u_sva (.core_clk, .sys_rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .poll_timer_test, .irq_timer_test, .test_collision,
  .test_backoff_value, .test_retry_limit, .mdc, .mdio_out, .mdio_oe);

// >>> verif/mdio_phy_model.sv
// Behavioural PHY on the management link: decodes frames, answers reads.
// Assumes the bench resolves the shared mdio line with a pull-up.
module mdio_phy_model #(
  parameter logic [15:0] READ_VALUE = 16'hC3A5 // Returned on every read.
) (
  input  wire logic  mdc,       // Management clock from the block.
  input  wire logic  mdio,      // Resolved line level.
  output logic       phy_out,   // Driven level.
  output logic       phy_oe,    // High while driving.
  output logic [1:0] op_seen,   // Last opcode.
  output logic [4:0] phy_seen,  // Last port id.
  output logic [4:0] reg_seen,  // Last register index.
  output logic [15:0] data_seen, // Last frame data.
  output int         frames     // Frames decoded.
);
  timeunit 1ns;
  timeprecision 1ps;
  int b = 0;
  int ones = 0;
  logic [63:0] fr = '0;
  initial begin
    phy_oe = 0;
    phy_out = 0;
    frames = 0;
  end
  // Bits are taken at mdc rise; a frame opens after 32 ones and a zero.
  always @(posedge mdc) begin
    if (b == 0) begin
      ones = (mdio === 1'b1) ? ones + 1 : 0;
      if (mdio === 1'b0 && ones == 0 && fr[0] === 1'b1) b = 33;
      fr[0] = (ones >= 32);
    end else begin
      fr[63 - b] = mdio;
      b++;
      if (b == 64) begin
        {op_seen, phy_seen, reg_seen} = fr[29:18];
        data_seen = fr[15:0];
        frames++;
        b = 0;
      end
    end
  end
  // Read data changes on mdc fall.
  always @(negedge mdc) begin
    phy_oe = (b >= 47) && (fr[29:28] == 2'b10);
    phy_out = (b == 47) ? 1'b0 : READ_VALUE[(63 - b) & 15];
  end
endmodule : mdio_phy_model

// >>> verif/tb_top.sv
// Self-checking bench for the MAC status and PHY management block.
// Assumes APB master timing and a pull-up on the shared mdio line.
module tb_top;
  import mac_stat_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    mac_event_s  e;
    logic [2:0]  ctl;
    logic [11:0] mask;
    logic [11:0] exp;
  } row_s;
  logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, w;
  logic pready, pslverr, er, mdc, mdio_out, mdio_oe, phy_out, phy_oe, mdio_line;
  logic fcs_check_off = 0, jumbo_length_select = 0, rx_runt_accept = 0;
  logic poll_timer_test, irq_timer_test, test_collision;
  logic [9:0] test_backoff_value;
  logic [4:0] test_retry_limit, phy_seen, reg_seen;
  logic [1:0] op_seen;
  logic [15:0] data_seen;
  mac_event_s evt = '0;
  row_s rows [15];
  int frames, fail_count = 0, checks_done = 0, cyc = 0;
  time t0;
  initial forever #5 core_clk = ~core_clk;
  assign mdio_line = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);
  mac_status_regs u_dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .evt, .fcs_check_off, .jumbo_length_select, .rx_runt_accept,
    .poll_timer_test, .irq_timer_test, .test_collision, .test_backoff_value,
    .test_retry_limit, .mdc, .mdio_in(mdio_line), .mdio_out, .mdio_oe);
  mdio_phy_model u_phy (.mdc, .mdio(mdio_line), .phy_out, .phy_oe, .op_seen, .phy_seen,
    .reg_seen, .data_seen, .frames);
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  always @(posedge core_clk) begin
    cyc++;
    if (mdio_oe === 1'b1 && phy_oe === 1'b1) check("mdio_contention", 1, 0);
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic pulse(input mac_event_s e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
  endtask : pulse
  task automatic reset_dut;
    sys_rst <= 1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 0;
  endtask : reset_dut
  function automatic mac_event_s tx(logic ok, logic late, logic [4:0] cnt);
    tx = '0;
    {tx.tx_end, tx.tx_ok, tx.tx_late_col, tx.tx_col_count} = {1'b1, ok, late, cnt};
  endfunction : tx
  function automatic mac_event_s rx(logic [13:0] len, logic [5:0] f);
    rx = '0;
    {rx.rx_end, rx.rx_len} = {1'b1, len};
    {rx.rx_vlan, rx.rx_crc_bad, rx.rx_fifo_full, rx.rx_col, rx.rx_bcast, rx.rx_mcast} = f;
  endfunction : rx
  task automatic mgmt(input int go, input logic [4:0] rg, input logic [4:0] ph);
    logic [31:0] c;
    c = 32'h0000_0010;
    c[go] = 1'b1;
    c[PC_REG_HI:PC_REG_LO] = rg;
    c[PC_PHY_HI:PC_PHY_LO] = ph;
    apb(1, PHY_MGMT_CONTROL_OFS, c);
    @(posedge mdc);
    t0 = $time;
    @(posedge mdc);
    check("mdc_period", 32'(($time - t0) / 10), 32'h10);
    do begin
      apb(0, PHY_MGMT_CONTROL_OFS, 0);
    end while (rd[go] !== 1'b0);
    check("mgmt_ctl_done", rd, c & ~(32'h1 << go));
    check("phy_frame", {op_seen, phy_seen, reg_seen}, {go == PC_WR ? 2'b01 : 2'b10, ph, rg});
  endtask : mgmt
  initial begin
    rows[0] = '{tx(1, 0, 0), 3'b000, 12'hFFF, 12'h100};
    rows[1] = '{tx(0, 0, 16), 3'b000, 12'hFFF, 12'hA00};
    rows[2] = '{tx(0, 0, 15), 3'b000, 12'hFFF, 12'h000};
    rows[3] = '{tx(0, 1, 3), 3'b000, 12'hFFF, 12'h600};
    rows[4] = '{rx(100, 6'h02), 3'b000, 12'hFFF, 12'h00A};
    rows[5] = '{rx(64, 6'h01), 3'b000, 12'h08B, 12'h009};
    rows[6] = '{rx(63, 6'h00), 3'b000, 12'h080, 12'h080};
    rows[7] = '{rx(63, 6'h00), 3'b001, 12'h080, 12'h000};
    rows[8] = '{rx(1519, 6'h00), 3'b000, 12'h040, 12'h040};
    rows[9] = '{rx(1522, 6'h20), 3'b000, 12'h040, 12'h000};
    rows[10] = '{rx(1519, 6'h00), 3'b010, 12'h040, 12'h000};
    rows[11] = '{rx(100, 6'h10), 3'b000, 12'h020, 12'h020};
    rows[12] = '{rx(100, 6'h10), 3'b100, 12'h020, 12'h000};
    rows[13] = '{rx(100, 6'h08), 3'b000, 12'h010, 12'h010};
    rows[14] = '{rx(100, 6'h04), 3'b000, 12'h004, 12'h004};
    reset_dut();
    foreach (rows[i]) begin
      {fcs_check_off, jumbo_length_select, rx_runt_accept} <= rows[i].ctl;
      pulse(rows[i].e);
      apb(0, MAC_EVENT_STATUS_OFS, 0);
      check("status_row", rd & rows[i].mask, rows[i].exp);
      apb(1, MAC_EVENT_STATUS_OFS, 32'hFFFF_FFFF);
      apb(0, MAC_EVENT_STATUS_OFS, 0);
      check("status_clear", rd, 0);
    end
    {fcs_check_off, jumbo_length_select, rx_runt_accept} <= 3'b000;
    pulse(tx(1, 0, 0));
    apb(1, MAC_EVENT_STATUS_OFS, 0);
    fork
      apb(1, MAC_EVENT_STATUS_OFS, 32'h0000_0100);
      begin
        @(posedge core_clk);
        @(posedge core_clk);
        evt <= tx(1, 0, 0);
        @(posedge core_clk);
        evt <= '0;
      end
    join
    apb(0, MAC_EVENT_STATUS_OFS, 0);
    check("status_event_wins", rd, 32'h0000_0100);
    // Reset values first, then each test field through its register and pins.
    reset_dut();
    apb(0, TEST_CONTROL_OFS, 0);
    check("test_ctl_reset", rd, 0);
    apb(0, PHY_MGMT_CONTROL_OFS, 0);
    check("mgmt_ctl_reset", rd, PHY_MGMT_CONTROL_RST);
    for (int k = 0; k < 2; k++) begin
      w = k ? 32'h0010_82A5 : 32'hFFFF_FFFF;
      apb(1, TEST_CONTROL_OFS, w);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      check("test_pins", {poll_timer_test, irq_timer_test, test_collision, test_backoff_value,
            test_retry_limit}, {w[20], w[19], w[15], w[14:5], w[4:0]});
      apb(0, TEST_CONTROL_OFS, 0);
      check("test_ctl_read", rd, w & 32'h0018_FFFF);
    end
    apb(1, 8'h5C, 32'hFFFF_FFFF);
    check("unmapped_err", er, 1);
    apb(1, PHY_MGMT_CONTROL_OFS, 32'h0000_0010);
    apb(1, PHY_MGMT_DATA_OFS, 32'h1234_BEEF);
    apb(0, PHY_MGMT_DATA_OFS, 0);
    check("data_read_only", rd, 32'h0000_BEEF);
    mgmt(PC_WR, 5'd5, 5'd9);
    check("phy_wdata", data_seen, 32'h0000_BEEF);
    mgmt(PC_RD, 5'd3, 5'd17);
    apb(0, PHY_MGMT_DATA_OFS, 0);
    check("phy_rdata", rd, {16'hC3A5, 16'hBEEF});
    check("frame_count", 32'(frames), 2);
    reset_dut();
    apb(0, PHY_MGMT_CONTROL_OFS, 0);
    check("mgmt_ctl_rerst", rd, PHY_MGMT_CONTROL_RST);
    print_verdict();
  end
endmodule : tb_top
